// [include/comma_align_regs.vh]
// Register map, codes and timing constants of the comma aligner and filler checker
`ifndef COMMA_ALIGN_REGS_VH
`define COMMA_ALIGN_REGS_VH
`define A_CTRL 12'h000
`define A_SAMPLE 12'h004
`define A_STATUS 12'h008
`define A_ERRCNT 12'h00C
`define A_CAPTURE 12'h010
`define A_EYE 12'h014
`define A_RATE 12'h018
`define A_FILL_BASE 6'h10
`define CTRL_RESET 32'h0000_0008
`define FILL0_RESET 48'hB63_955_955_8FA
`define C_COMMAND_A 16
`define C_AUTOALIGN 17
`define C_CLRCNT 18
`define K285 10'h0FA
`define K281 10'h0F9
`define K287 10'h0F8
`define SEL_K281 2'h1
`define SEL_K287 2'h2
`define LK_NONE 2'h0
`define LK_ALIGNED 2'h1
`define LK_LOST 2'h2
`define SYM_BITS 4'hA
`define LOSS_LIMIT 3'h4
`define REF_RATE_LIMIT_MBPS 16'd11500
`define CLK_PERIOD_PS 40000
`define DELAY_MAX_PS 10000
`define DELAY_MAX_CYC ((`DELAY_MAX_PS / `CLK_PERIOD_PS) < 1 ? 1 : (`DELAY_MAX_PS / `CLK_PERIOD_PS))
`endif

// [hw/comma_align_checker.v]
// Comma aligner, filler checker, line-code and reference-sampler checker with APB registers
`timescale 1ns/1ps
`include "comma_align_regs.vh"
module comma_align_checker (
  input wire clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire serClk,
  input wire [7:0] dataLevel,
  input wire [1:0] eieosLock,
  output reg [1:0] lockStatus,
  output reg lineCodeErrorFlag,
  output reg referenceSamplerMode,
  output reg patternSyncEnable,
  output reg burstEnable,
  output reg captureEnable,
  output reg tracksGenerator
);
  function [2:0] ones;
    input [5:0] v;
    integer i;
    begin
      ones = 3'h0;
      for (i = 0; i < 6; i = i + 1) begin
        ones = ones + {2'h0, v[i]};
      end
    end
  endfunction
  function isComma;
    input [9:0] s;
    input [1:0] sel;
    reg [9:0] k;
    begin
      k = (sel == `SEL_K281) ? `K281 : (sel == `SEL_K287) ? `K287 : `K285;
      isComma = (s == k) || (s == ~k);
    end
  endfunction
  function [3:0] clampDelay;
    input [3:0] d;
    input [3:0] per;
    reg [3:0] m;
    reg [31:0] mx;
    begin
      mx = `DELAY_MAX_CYC;
      m = mx[3:0];
      if (per < m) m = per;
      clampDelay = (d > m) ? m : d;
    end
  endfunction
  // Control and status registers
  reg manualMode, refMode, eieosMode, syncReq, burstReq, capReq, cdrEnable;
  reg [1:0] commaSel;
  reg [7:0] userThr, optThr, refThr;
  reg [3:0] userDelay, optDelay, refDelay;
  reg [15:0] curRatio, adjRatio, alignThr, lineRate;
  reg [11:0] fdef [0:15];
  reg realignReq, clrCnt;
  reg [31:0] errCount;
  reg [11:0] capture;
  reg codeErrSticky;
  reg [1:0] lockState;
  wire wrEn = psel & penable & pwrite & pready;
  wire setup = psel & ~penable;
  wire fillHit = (paddr[11:6] == 6'h01);
  wire [3:0] fillIdx = paddr[5:2];
  wire eyeEdge = (curRatio >= alignThr) && (adjRatio < alignThr);
  reg [31:0] rdMux;
  reg rdErrBus;
  always @* begin
    rdMux = 32'h0;
    rdErrBus = 1'b0;
    if (fillHit) begin
      rdMux = {20'h0, fdef[fillIdx]};
    end else begin
      case (paddr)
        `A_CTRL: rdMux = {22'h0, commaSel, cdrEnable, capReq, burstReq, syncReq,
                          tracksGenerator, eieosMode, refMode, manualMode};
        `A_SAMPLE: rdMux = {4'h0, optDelay, optThr, 4'h0, userDelay, userThr};
        `A_STATUS: rdMux = {27'h0, refMode, eyeEdge, codeErrSticky, lockStatus};
        `A_ERRCNT: rdMux = errCount;
        `A_CAPTURE: rdMux = {20'h0, capture};
        `A_EYE: rdMux = {adjRatio, curRatio};
        `A_RATE: rdMux = {lineRate, alignThr};
        default: rdErrBus = 1'b1;
      endcase
    end
  end
  // Answer in the first access cycle; the next setup may follow at once
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup & rdErrBus;
      prdata <= (setup & ~pwrite) ? rdMux : 32'h0;
    end
  end
  wire [47:0] fill0Rst = `FILL0_RESET;
  wire refAllowed = ~(pwdata[7] & (lineRate > `REF_RATE_LIMIT_MBPS));
  integer j;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      manualMode <= 1'b0;
      refMode <= 1'b0;
      eieosMode <= 1'b0;
      tracksGenerator <= 1'b1;
      syncReq <= 1'b0;
      burstReq <= 1'b0;
      capReq <= 1'b0;
      cdrEnable <= 1'b0;
      commaSel <= 2'h0;
      userThr <= 8'h80;
      userDelay <= 4'h0;
      optThr <= 8'h80;
      optDelay <= 4'h0;
      refThr <= 8'h80;
      refDelay <= 4'h0;
      curRatio <= 16'h0;
      adjRatio <= 16'h0;
      alignThr <= 16'h0;
      lineRate <= 16'h0;
      realignReq <= 1'b0;
      clrCnt <= 1'b0;
      for (j = 0; j < 16; j = j + 1) begin
        fdef[j] <= 12'h0;
      end
      fdef[0] <= fill0Rst[11:0];
      fdef[1] <= fill0Rst[23:12];
      fdef[2] <= fill0Rst[35:24];
      fdef[3] <= fill0Rst[47:36];
    end else begin
      realignReq <= 1'b0;
      clrCnt <= 1'b0;
      if (wrEn && fillHit) begin
        fdef[fillIdx] <= pwdata[11:0];
      end
      if (wrEn && paddr == `A_CTRL) begin
        manualMode <= pwdata[0];
        refMode <= pwdata[1] & refAllowed;
        eieosMode <= pwdata[2];
        // A refused entry into reference mode leaves pattern tracking alone
        tracksGenerator <= pwdata[3] & ~(pwdata[1] & refAllowed) & ~refMode;
        syncReq <= pwdata[4];
        burstReq <= pwdata[5];
        capReq <= pwdata[6];
        cdrEnable <= pwdata[7];
        commaSel <= pwdata[9:8];
        realignReq <= pwdata[`C_COMMAND_A] & pwdata[0];
        clrCnt <= pwdata[`C_CLRCNT];
        if (pwdata[`C_AUTOALIGN]) begin
          userThr <= optThr;
          userDelay <= optDelay;
          refThr <= optThr;
          refDelay <= optDelay;
        end
      end
      if (wrEn && paddr == `A_SAMPLE) begin
        userThr <= pwdata[7:0];
        userDelay <= pwdata[11:8];
        optThr <= pwdata[23:16];
        optDelay <= pwdata[27:24];
      end
      if (wrEn && paddr == `A_EYE) begin
        curRatio <= pwdata[15:0];
        adjRatio <= pwdata[31:16];
      end
      if (wrEn && paddr == `A_RATE) begin
        alignThr <= pwdata[15:0];
        lineRate <= pwdata[31:16];
      end
    end
  end
  // Link side: two flops on serClk and dataLevel before use; eieosLock gets only the lockStatus flop
  reg [2:0] clkSync;
  reg [7:0] lvlMeta, lvl;
  reg [3:0] cnt, period, perCnt;
  reg uBit, rBit, bitEv;
  wire linkRise = clkSync[1] & ~clkSync[2];
  wire [3:0] dU = clampDelay(userDelay, period);
  wire [3:0] dR = clampDelay(refDelay, period);
  wire [3:0] dLast = (dU > dR) ? dU : dR;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clkSync <= 3'h0;
      lvlMeta <= 8'h0;
      lvl <= 8'h0;
      cnt <= 4'hF;
      perCnt <= 4'h0;
      period <= 4'hF;
      uBit <= 1'b0;
      rBit <= 1'b0;
      bitEv <= 1'b0;
    end else begin
      clkSync <= {clkSync[1:0], serClk};
      lvlMeta <= dataLevel;
      lvl <= lvlMeta;
      bitEv <= 1'b0;
      if (linkRise) begin
        cnt <= 4'h0;
        perCnt <= 4'h1;
        period <= perCnt;
      end else begin
        if (cnt != 4'hF) cnt <= cnt + 4'h1;
        if (perCnt != 4'hF) perCnt <= perCnt + 4'h1;
      end
      // Delay counts from the detected edge, so it carries the sync latency
      if (cnt == dU) uBit <= (lvl > userThr);
      if (cnt == dR) rBit <= (lvl > refThr);
      if (cnt == dLast + 4'h1) bitEv <= 1'b1;
    end
  end
  // Hidden sampler carries the stream in reference mode
  wire rxBit = refMode ? rBit : uBit;
  reg [8:0] sr;
  reg [3:0] bitCnt;
  reg rd;
  reg [2:0] errRun;
  wire [9:0] sym = {sr, rxBit};
  wire hit = isComma(sym, commaSel);
  wire searching = (lockState != `LK_ALIGNED);
  wire rephase = ~manualMode & hit & (bitCnt != `SYM_BITS - 4'h1);
  wire symDone = bitEv & ((searching & hit) | (~searching & ~rephase &
                 (bitCnt == `SYM_BITS - 4'h1)));
  wire [2:0] o6 = ones(sym[9:4]);
  wire [2:0] o4 = ones({2'h0, sym[3:0]});
  wire undec = (o6 < 3'h2) | (o6 > 3'h4) | (o4 < 3'h1) | (o4 > 3'h3);
  wire rdMid = (o6 == 3'h4) ? 1'b1 : (o6 == 3'h2) ? 1'b0 : rd;
  wire rdErr = ((o6 == 3'h4) & rd) | ((o6 == 3'h2) & ~rd) |
               ((sym[9:4] == 6'h38) & rd) | ((sym[9:4] == 6'h07) & ~rd) |
               ((o4 == 3'h3) & rdMid) | ((o4 == 3'h1) & ~rdMid) |
               ((sym[3:0] == 4'hC) & rdMid) | ((sym[3:0] == 4'h3) & ~rdMid);
  wire rdNext = (o4 == 3'h3) ? 1'b1 : (o4 == 3'h1) ? 1'b0 : rdMid;
  wire codeErr = undec | rdErr;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sr <= 9'h0;
      bitCnt <= 4'h0;
      rd <= 1'b0;
      errRun <= 3'h0;
      lockState <= `LK_NONE;
    end else begin
      if (bitEv) begin
        sr <= sym[8:0];
        if (symDone | rephase | (bitCnt == `SYM_BITS - 4'h1)) bitCnt <= 4'h0;
        else bitCnt <= bitCnt + 4'h1;
      end
      if (symDone) begin
        rd <= rdNext;
        if (codeErr) errRun <= errRun + 3'h1;
        else errRun <= 3'h0;
      end
      case (lockState)
        `LK_NONE, `LK_LOST: begin
          // Every mode locks on the first comma seen at a bit event; aligned is left only on errors or a manual realign
          if (bitEv & hit) begin
            lockState <= `LK_ALIGNED;
            errRun <= 3'h0;
          end
        end
        `LK_ALIGNED: begin
          if (realignReq) lockState <= `LK_NONE;
          else if (symDone & codeErr & (errRun == `LOSS_LIMIT - 3'h1)) lockState <= `LK_LOST;
        end
        default: lockState <= `LK_NONE;
      endcase
    end
  end
  // Four-symbol window: a symbol leaves only once every filler that could hold it is seen
  reg [9:0] pCode [0:3];
  reg [3:0] pVal, pFill, pErr, pUnd;
  reg [9:0] vCode [0:3];
  reg [3:0] vVal, vUnd, mark;
  reg [2:0] len;
  reg ok, slotOk;
  reg [1:0] e;
  reg [11:0] f;
  integer d, k;
  always @* begin
    vCode[0] = sym;
    vVal[0] = 1'b1;
    vUnd[0] = undec;
    for (k = 1; k < 4; k = k + 1) begin
      vCode[k] = pCode[k - 1];
      vVal[k] = pVal[k - 1];
      vUnd[k] = pUnd[k - 1];
    end
    mark = 4'h0;
    len = 3'h0;
    ok = 1'b0;
    slotOk = 1'b0;
    e = 2'h0;
    f = 12'h0;
    for (d = 0; d < 4; d = d + 1) begin
      len = {2'h0, fdef[d * 4][11]} + {2'h0, fdef[d * 4 + 1][11]} +
            {2'h0, fdef[d * 4 + 2][11]} + {2'h0, fdef[d * 4 + 3][11]};
      ok = (len != 3'h0);
      for (k = 0; k < 4; k = k + 1) begin
        f = fdef[d * 4 + k];
        e = len[1:0] - 2'h1 - k[1:0];
        slotOk = f[10] ? ~vUnd[e] : ((vCode[e] == f[9:0]) | (vCode[e] == ~f[9:0]));
        if (f[11] && !(vVal[e] && slotOk)) ok = 1'b0;
      end
      if (ok) begin
        for (k = 0; k < 4; k = k + 1) begin
          if (k < len) mark[k] = 1'b1;
        end
      end
    end
  end
  wire leaveErr = pVal[3] & ~pFill[3] & pErr[3];
  integer q;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (q = 0; q < 4; q = q + 1) begin
        pCode[q] <= 10'h0;
      end
      pVal <= 4'h0;
      pFill <= 4'h0;
      pErr <= 4'h0;
      pUnd <= 4'h0;
    end else if (searching) begin
      pVal <= 4'h0;
      pFill <= 4'h0;
    end else if (symDone) begin
      for (q = 1; q < 4; q = q + 1) begin
        pCode[q] <= pCode[q - 1];
      end
      pCode[0] <= sym;
      pVal <= {pVal[2:0], 1'b1};
      pErr <= {pErr[2:0], codeErr};
      pUnd <= {pUnd[2:0], undec};
      pFill <= {pFill[2:0], 1'b0} | mark;
    end
  end
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      errCount <= 32'h0;
      capture <= 12'h0;
      codeErrSticky <= 1'b0;
      lockStatus <= `LK_NONE;
      lineCodeErrorFlag <= 1'b0;
      referenceSamplerMode <= 1'b0;
      patternSyncEnable <= 1'b0;
      burstEnable <= 1'b0;
      captureEnable <= 1'b0;
    end else begin
      if (clrCnt) errCount <= 32'h0;
      else if (refMode & bitEv & (uBit != rBit)) errCount <= errCount + 32'h1;
      else if (~refMode & symDone & ~searching & leaveErr) errCount <= errCount + 32'h1;
      if (symDone & ~refMode) capture <= {rdErr, undec, sym};
      // A new error wins over the clear written in the same cycle
      if (symDone & codeErr) codeErrSticky <= 1'b1;
      else if (wrEn && paddr == `A_STATUS && pwdata[2]) codeErrSticky <= 1'b0;
      lineCodeErrorFlag <= codeErrSticky | (symDone & codeErr);
      lockStatus <= eieosMode ? eieosLock : lockState;
      referenceSamplerMode <= refMode;
      patternSyncEnable <= syncReq & ~refMode;
      burstEnable <= burstReq & ~refMode;
      captureEnable <= capReq & ~refMode;
    end
  end
endmodule

// [sim/comma_align_props_checker.sv]
// Concurrent checks on the register bus and status outputs of the aligner
`timescale 1ns/1ps
`include "comma_align_regs.vh"
module comma_align_props (
  input wire clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [1:0] lockStatus,
  input wire referenceSamplerMode,
  input wire patternSyncEnable,
  input wire burstEnable,
  input wire captureEnable,
  input wire tracksGenerator
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence apbSetup;
    psel && !penable;
  endsequence
  sequence lostEntry;
    lockStatus == `LK_LOST && $past(lockStatus) != `LK_LOST;
  endsequence
  ready_after_setup_a: assert property (apbSetup |=> pready)
    else $error("pready missing after setup");
  ready_from_setup_a: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready held two cycles");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  lock_code_a: assert property (lockStatus != 2'h3)
    else $error("illegal lock code");
  lost_from_aligned_a: assert property (lostEntry |-> $past(lockStatus) == `LK_ALIGNED)
    else $error("lost entered from not aligned");
  ref_blocks_a: assert property (referenceSamplerMode |-> !(patternSyncEnable || burstEnable || captureEnable))
    else $error("sync, burst or capture active in reference mode");
  ref_clears_a: assert property ($rose(referenceSamplerMode) |-> ##[0:1] !tracksGenerator)
    else $error("pattern tracking kept on entering reference mode");
endmodule
bind comma_align_checker comma_align_props chkU (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .lockStatus(lockStatus),
  .referenceSamplerMode(referenceSamplerMode), .patternSyncEnable(patternSyncEnable), .burstEnable(burstEnable),
  .captureEnable(captureEnable), .tracksGenerator(tracksGenerator));

// [sim/serial_source.sv]
// Far-side serial source: link clock and sampled data level
`timescale 1ns/1ps
module serial_source (
  output logic serClk,
  output logic [7:0] dataLevel
);
  logic rd = 1'b0;
  initial begin
    serClk = 1'b0;
    dataLevel = 8'h10;
  end
  // Clock stands still between symbols; data flips so a stale bit is never reused
  task sendSym(input logic [9:0] s);
    integer i;
    integer ones;
    logic [9:0] c;
    begin
      ones = $countones(s);
      c = (ones != 5 && rd == (ones > 5)) ? ~s : s;
      if (ones != 5)
        rd = ~rd;
      for (i = 9; i >= 0; i--) begin
        dataLevel = c[i] ? 8'hF0 : 8'h10;
        #160 serClk = 1'b1;
        #160 serClk = 1'b0;
      end
      dataLevel = c[0] ? 8'h10 : 8'hF0;
      // Idle bit time lets the last bit event and lock status settle before a read
      #320;
    end
  endtask
endmodule

// [sim/comma_align_checker_test.sv]
// Self-checking bench for the comma aligner and filler checker
`timescale 1ns/1ps
`include "comma_align_regs.vh"
module comma_align_checker_test;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] eieosLock = 2'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire serClk;
  wire [7:0] dataLevel;
  wire [1:0] lockStatus;
  wire lineCodeErrorFlag;
  wire referenceSamplerMode;
  wire patternSyncEnable;
  wire burstEnable;
  wire captureEnable;
  wire tracksGenerator;
  integer err_total = 0;
  integer samples_checked = 0;
  integer seed = 32'h7477;
  integer i;
  logic [31:0] r;
  logic [31:0] expQ[$];
  logic [31:0] maskQ[$];
  logic errQ[$];
  logic [9:0] commaTab[3] = '{`K285, `K281, `K287};
  always #20 clk = ~clk;
  comma_align_checker dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serClk(serClk),
    .dataLevel(dataLevel), .eieosLock(eieosLock), .lockStatus(lockStatus), .lineCodeErrorFlag(lineCodeErrorFlag),
    .referenceSamplerMode(referenceSamplerMode), .patternSyncEnable(patternSyncEnable), .burstEnable(burstEnable),
    .captureEnable(captureEnable), .tracksGenerator(tracksGenerator));
  serial_source srcU (.serClk(serClk), .dataLevel(dataLevel));
  task wrap_up;
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task checkData(input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("BAD prdata expected %h seen %h", e, s);
    end
  endtask
  task checkPin(input logic [5:0] e, input logic [5:0] s);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("BAD pins expected %h seen %h", e, s);
    end
  endtask
  task checkResp(input logic e, input logic s);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("BAD pslverr expected %b seen %b", e, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
      input logic [31:0] m, input logic er);
    integer n;
    begin
      expQ.push_back(e & m);
      maskQ.push_back(m);
      errQ.push_back(er);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge clk);
        n++;
      end
      if (n == 20) begin
        err_total++;
        wrap_up();
      end
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'hFFFFFFFF, 1'b0);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, e, m, 1'b0);
  endtask
  task resetDut;
    sys_rst <= 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  // Results are matched in issue order; the bus never has two accesses open
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (expQ.size() == 0) begin
        err_total++;
        $display("BAD pready expected 0 seen 1");
      end else begin
        checkData(expQ.pop_front(), prdata & maskQ.pop_front());
        checkResp(errQ.pop_front(), pslverr);
      end
    end
  end
  initial begin
    #1000000;
    err_total++;
    wrap_up();
  end
  initial begin
    resetDut();
    rd(`A_CTRL, `CTRL_RESET, 32'hFFFFFFFF);
    rd(`A_SAMPLE, 32'h00800080, 32'hFFFFFFFF);
    rd(12'h040, 32'h8FA, 32'hFFF);
    rd(12'h044, 32'h955, 32'hFFF);
    r = 32'h1C + 4 * ($unsigned($random(seed)) % 9);
    apb(1'b0, r[11:0], 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
    apb(1'b1, r[11:0], 32'h5, 32'h0, 32'hFFFFFFFF, 1'b1);
    r = $random(seed) & 32'hFFF;
    wr(12'h07C, r);
    rd(12'h07C, r, 32'hFFF);
    for (i = 0; i < 3; i++) begin
      resetDut();
      wr(`A_CTRL, 32'h8 | (i << 8));
      srcU.sendSym(commaTab[i]);
      srcU.sendSym(10'h155);
      srcU.sendSym(commaTab[i]);
      srcU.sendSym(10'h155);
      rd(`A_STATUS, `LK_ALIGNED, 32'h3);
    end
    wr(`A_STATUS, 32'h4);
    srcU.sendSym(10'h155);
    rd(`A_STATUS, `LK_ALIGNED, 32'h7);
    repeat (4) srcU.sendSym(10'h000);
    rd(`A_STATUS, 32'h4 | `LK_LOST, 32'h7);
    rd(`A_CAPTURE, 32'h400, 32'h400);
    checkPin(6'h21, {lineCodeErrorFlag, referenceSamplerMode, patternSyncEnable, burstEnable, captureEnable,
      tracksGenerator});
    srcU.sendSym(`K287);
    srcU.sendSym(10'h155);
    rd(`A_STATUS, `LK_ALIGNED, 32'h3);
    eieosLock <= 2'h1;
    wr(`A_CTRL, 32'h20C);
    rd(`A_STATUS, `LK_ALIGNED, 32'h3);
    eieosLock <= 2'h2;
    rd(`A_STATUS, `LK_LOST, 32'h3);
    wr(`A_CTRL, 32'h208);
    for (i = 0; i < 3; i++) begin
      wr(`A_EYE, ((i == 2 ? 100 : 99) << 16) | (i == 1 ? 99 : 100));
      wr(`A_RATE, 32'd100);
      rd(`A_STATUS, i == 0 ? 32'h8 : 32'h0, 32'h8);
    end
    for (i = 0; i < 2; i++) begin
      wr(`A_CTRL, 32'h8);
      wr(`A_RATE, (11500 + i) << 16);
      wr(`A_CTRL, 32'hFA);
      rd(`A_STATUS, i ? 32'h0 : 32'h10, 32'h10);
      rd(`A_CTRL, i ? 32'h8 : 32'h2, 32'hA);
      checkPin(i ? 6'h2F : 6'h30, {lineCodeErrorFlag, referenceSamplerMode, patternSyncEnable, burstEnable,
        captureEnable, tracksGenerator});
    end
    wrap_up();
  end
endmodule
